// ---- scs_defs.svh ----
// Constants for the strap configuration source switch
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_SRC_A        2'h0
`define SCS_SRC_B        2'h1
`define SCS_SRC_C        2'h2
`define SCS_SRC_D        2'h3
`define SCS_EQ_LOW_DB    6
`define SCS_EQ_HIGH_DB   12
`define SCS_PE_NONE      2'h0
`define SCS_PE_LOW       2'h1
`define SCS_PE_MED       2'h2
`define SCS_PE_HIGH      2'h3
`define SCS_OCL_LOW_MA   10
`define SCS_OCL_HIGH_MA  20
`define SCS_RST_SRC      2'h0
`define SCS_RST_PE       2'h0
`define SCS_SETTLE_CNT   2'h2
`define SCS_F_EN         7
`define SCS_F_SRC_HI     6
`define SCS_F_SRC_LO     5
`define SCS_F_EQ         4
`define SCS_F_PE_HI      3
`define SCS_F_PE_LO      2
`define SCS_F_OTO        1
`define SCS_F_OCL        0
`endif

// ---- scs_pkg.sv ----
// Types for the strap configuration source switch
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_WAIT  = 2'b00,
    SCS_STRAP = 2'b01,
    SCS_SER   = 2'b11
  } scs_mode_e;
  typedef logic [1:0] scs_sel_t;
endpackage : scs_pkg

// ---- scs_strap_config.sv ----
// Strap pin decode into source switch control settings
//
// Contract
// - Enable strap low: lanes off, standby; aux lines stay routed
// - Select strap routes source lanes to output
// - Select strap routes auxiliary lines to common
// - Input terminations always on in strap mode
// - Termination pulse on switching always off
// - One equalization strap: 6 or 12 dB
// - Pre-emphasis strap: 0, 2, 4, 6 dB
// - Output termination strap: 0 off, 1 on
// - Output current strap: 10 or 20 mA
// - Straps apply after reset until serial access
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_strap_config (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Strap pins
  input  wire logic             lane_enable_strap,
  input  wire scs_pkg::scs_sel_t source_select_strap,
  input  wire logic             equalization_strap,
  input  wire scs_pkg::scs_sel_t preemphasis_strap,
  input  wire logic             output_termination_strap,
  input  wire logic             output_current_strap,
  // Serial control takeover
  input  wire logic             serial_access,
  // Decoded settings
  output logic                  lanes_on,
  output logic                  standby,
  output logic [3:0]            lane_source_onehot,
  output logic [3:0]            aux_source_onehot,
  output scs_pkg::scs_sel_t     lane_source,
  output scs_pkg::scs_sel_t     aux_source,
  output logic                  input_term_on,
  output logic                  term_pulse_on,
  output logic                  eq_high,
  output logic [3:0]            eq_level_db,
  output scs_pkg::scs_sel_t     preemphasis_level,
  output logic [2:0]            preemphasis_db,
  output logic                  output_term_on,
  output logic                  output_current_high,
  output logic [4:0]            output_current_ma,
  output logic                  strap_mode
);
  import scs_pkg::*;

  // Two-stage synchronisers: straps are asynchronous pins
  // One bit per strap pin; a wider bus would zero-pad above the enable bit and leave every field in place
  localparam int unsigned SW = 8;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic          ser1;
  logic          ser2;
  wire  [SW-1:0] raw_pins = {lane_enable_strap, source_select_strap, equalization_strap,
                             preemphasis_strap, output_termination_strap, output_current_strap};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
      ser1  <= 1'b0;
      ser2  <= 1'b0;
    end else begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      ser1  <= serial_access;
      ser2  <= ser1;
    end
  end

  // Mode: wait for synchronised levels, apply once, freeze on serial access
  scs_mode_e mode;
  scs_mode_e next_mode;
  logic [1:0] settle;
  wire        settled = (settle == `SCS_SETTLE_CNT);

  always_comb begin
    next_mode = mode;
    unique case (mode)
      SCS_WAIT:  if (ser2) next_mode = SCS_SER; else if (settled) next_mode = SCS_STRAP;
      SCS_STRAP: if (ser2) next_mode = SCS_SER;
      SCS_SER:   next_mode = SCS_SER;
      default:   next_mode = SCS_WAIT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode   <= SCS_WAIT;
      settle <= 2'h0;
    end else begin
      mode   <= next_mode;
      if (!settled) settle <= settle + 2'h1;
    end
  end

  // Capture only on entry to strap mode; held until next reset
  wire capture = (mode == SCS_WAIT) && (next_mode == SCS_STRAP);

  function automatic logic [3:0] scs_onehot(input scs_sel_t s);
    scs_onehot = 4'h1 << s;
  endfunction : scs_onehot

  wire           st_en   = sync2[`SCS_F_EN];
  wire scs_sel_t st_src  = sync2[`SCS_F_SRC_HI:`SCS_F_SRC_LO];
  wire           st_eq   = sync2[`SCS_F_EQ];
  wire scs_sel_t st_pe   = sync2[`SCS_F_PE_HI:`SCS_F_PE_LO];
  wire           st_oto  = sync2[`SCS_F_OTO];
  wire           st_ocl  = sync2[`SCS_F_OCL];
  wire [3:0]     st_eqdb = st_eq ? 4'(`SCS_EQ_HIGH_DB) : 4'(`SCS_EQ_LOW_DB);
  wire [2:0]     st_pedb = {st_pe, 1'b0};
  wire [4:0]     st_ma   = st_ocl ? 5'(`SCS_OCL_HIGH_MA) : 5'(`SCS_OCL_LOW_MA);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lanes_on            <= 1'b0;
      standby             <= 1'b1;
      lane_source         <= `SCS_RST_SRC;
      aux_source          <= `SCS_RST_SRC;
      lane_source_onehot  <= 4'h0;
      aux_source_onehot   <= 4'h0;
      input_term_on       <= 1'b1;
      term_pulse_on       <= 1'b0;
      eq_high             <= 1'b0;
      eq_level_db         <= 4'h0;
      preemphasis_level   <= `SCS_RST_PE;
      preemphasis_db      <= 3'h0;
      output_term_on      <= 1'b0;
      output_current_high <= 1'b0;
      output_current_ma   <= 5'h0;
      strap_mode          <= 1'b0;
    end else begin
      strap_mode <= (next_mode == SCS_STRAP);
      if (capture) begin
        lanes_on            <= st_en;
        standby             <= ~st_en;
        lane_source         <= st_src;
        lane_source_onehot  <= st_en ? scs_onehot(st_src) : 4'h0;
        aux_source          <= st_src;
        aux_source_onehot   <= scs_onehot(st_src);
        input_term_on       <= 1'b1;
        term_pulse_on       <= 1'b0;
        eq_high             <= st_eq;
        eq_level_db         <= st_eqdb;
        preemphasis_level   <= st_pe;
        preemphasis_db      <= st_pedb;
        output_term_on      <= st_oto;
        output_current_high <= st_ocl;
        output_current_ma   <= st_ma;
      end
    end
  end

  // Checks
  sequence s_capture;
    capture;
  endsequence

  sequence s_release;
    $rose(rst_b) ##0 !serial_access [*4];
  endsequence

  a_standby_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_capture |=> (standby == ~$past(st_en)) && (lanes_on == $past(st_en)))
    else $error("standby does not follow enable strap");
  a_lane_route: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_capture and st_en) |=> lane_source_onehot == (4'h1 << $past(st_src)))
    else $error("lane route mismatch");
  a_aux_route: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_capture |=> aux_source_onehot == (4'h1 << $past(st_src)) && aux_source == $past(st_src))
    else $error("aux route mismatch");
  a_term_fixed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    strap_mode |-> input_term_on && !term_pulse_on)
    else $error("input termination not fixed");
  a_eq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    strap_mode |-> eq_level_db == (eq_high ? 4'hc : 4'h6))
    else $error("equalization level wrong");
  a_pe_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    strap_mode |-> preemphasis_db == {preemphasis_level, 1'b0})
    else $error("pre-emphasis level wrong");
  a_oterm_follows: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_capture |=> output_term_on == $past(st_oto))
    else $error("output termination mismatch");
  a_current_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
    strap_mode |-> output_current_ma == (output_current_high ? 5'h14 : 5'h0a))
    else $error("output current wrong");
  a_serial_freeze: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode == SCS_SER |=> $stable(lane_source) && $stable(eq_high) && !strap_mode)
    else $error("settings changed after serial takeover");
  a_hold_settings: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !capture |=> $stable(preemphasis_level) && $stable(output_current_high))
    else $error("settings changed without capture");
  a_strap_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_release |-> ##[0:2] strap_mode)
    else $error("strap mode not entered");
  a_standby_lanes: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !lanes_on |-> standby && lane_source_onehot == 4'h0)
    else $error("lanes active in standby");
  a_lane_onehot: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lanes_on |-> lane_source_onehot == (4'h1 << lane_source))
    else $error("lane onehot disagrees with source");
  a_aux_onehot: assert property (@(posedge sys_clk) disable iff (!rst_b)
    strap_mode |-> aux_source_onehot == (4'h1 << aux_source))
    else $error("aux onehot disagrees with source");
  a_pulse_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    strap_mode |-> !term_pulse_on)
    else $error("termination pulse enabled");
  a_eq_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_capture |=> eq_high == $past(st_eq))
    else $error("equalization strap not captured");
  a_pe_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_capture |=> preemphasis_level == $past(st_pe))
    else $error("pre-emphasis strap not captured");
  a_current_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_capture |=> output_current_high == $past(st_ocl))
    else $error("output current strap not captured");
  a_serial_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mode == SCS_WAIT && ser2 |=> mode == SCS_SER && !strap_mode)
    else $error("straps applied after serial access");
endmodule : scs_strap_config

// ---- scs_strap_board.sv ----
// Board model that ties the strap pins to fixed levels
`timescale 1ns/1ps
module scs_strap_board (
  // Board wiring choice
  input  wire logic [7:0] board_cfg,
  // Strap pins
  output logic            lane_enable_strap,
  output logic [1:0]      source_select_strap,
  output logic            equalization_strap,
  output logic [1:0]      preemphasis_strap,
  output logic            output_termination_strap,
  output logic            output_current_strap
);
  // Straps are hard ties, so they only move when the bench rewires the board
  assign lane_enable_strap        = board_cfg[0];
  assign source_select_strap      = board_cfg[2:1];
  assign equalization_strap       = board_cfg[3];
  assign preemphasis_strap        = board_cfg[5:4];
  assign output_termination_strap = board_cfg[6];
  assign output_current_strap     = board_cfg[7];
endmodule : scs_strap_board

// ---- tb_top.sv ----
// Self-checking bench for the strap configuration decoder
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import scs_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, serial_access = 1'b0;
  logic [7:0] board_cfg = 8'h00;
  int err_total = 0, checks_done = 0;
  logic en_s, eq_s, ot_s, oc_s, lanes_on, standby, input_term_on, term_pulse_on, eq_high;
  logic output_term_on, output_current_high, strap_mode;
  scs_sel_t sel_s, pe_s, lane_source, aux_source, preemphasis_level;
  logic [3:0] lane_source_onehot, aux_source_onehot, eq_level_db;
  logic [2:0] preemphasis_db;
  logic [4:0] output_current_ma;
  always #4 sys_clk = ~sys_clk;
  scs_strap_board board_u (.board_cfg(board_cfg), .lane_enable_strap(en_s), .source_select_strap(sel_s),
    .equalization_strap(eq_s), .preemphasis_strap(pe_s), .output_termination_strap(ot_s), .output_current_strap(oc_s));
  scs_strap_config dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .lane_enable_strap(en_s), .source_select_strap(sel_s),
    .equalization_strap(eq_s), .preemphasis_strap(pe_s), .output_termination_strap(ot_s),
    .output_current_strap(oc_s), .serial_access(serial_access), .lanes_on(lanes_on), .standby(standby),
    .lane_source_onehot(lane_source_onehot), .aux_source_onehot(aux_source_onehot), .lane_source(lane_source),
    .aux_source(aux_source), .input_term_on(input_term_on), .term_pulse_on(term_pulse_on), .eq_high(eq_high),
    .eq_level_db(eq_level_db), .preemphasis_level(preemphasis_level), .preemphasis_db(preemphasis_db),
    .output_term_on(output_term_on), .output_current_high(output_current_high),
    .output_current_ma(output_current_ma), .strap_mode(strap_mode));
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic do_reset(input logic [7:0] c, input logic sa);
    int k;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    board_cfg <= c;
    serial_access <= sa;
    repeat (16) @(posedge sys_clk);
    `CHK("standby", 1'b1, standby)
    rst_b <= 1'b1;
    // Capture lands three edges after release; allow some slack
    for (k = 0; k < 10 && strap_mode !== 1'b1 && !sa; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (k == 10) begin
      err_total++;
      finish_test();
    end
  endtask : do_reset
  task automatic check_cfg(input logic [7:0] c);
    `CHK("lanes_on", c[0], lanes_on)
    `CHK("standby", ~c[0], standby)
    `CHK("lane_source", c[2:1], lane_source)
    `CHK("lane_onehot", c[0] ? 4'h1 << c[2:1] : 4'h0, lane_source_onehot)
    `CHK("aux_source", c[2:1], aux_source)
    `CHK("aux_onehot", 4'h1 << c[2:1], aux_source_onehot)
    `CHK("input_term_on", 1'b1, input_term_on)
    `CHK("term_pulse_on", 1'b0, term_pulse_on)
    `CHK("eq_high", c[3], eq_high)
    `CHK("eq_level_db", c[3] ? 4'hc : 4'h6, eq_level_db)
    `CHK("pe_level", c[5:4], preemphasis_level)
    `CHK("pe_db", {c[5:4], 1'b0}, preemphasis_db)
    `CHK("output_term_on", c[6], output_term_on)
    `CHK("current_high", c[7], output_current_high)
    `CHK("current_ma", c[7] ? 5'h14 : 5'ha, output_current_ma)
  endtask : check_cfg
  task automatic test_table;
    logic [7:0] tbl [4] = '{8'h01, 8'hda, 8'ha5, 8'h7f};
    foreach (tbl[i]) begin
      do_reset(tbl[i], 1'b0);
      check_cfg(tbl[i]);
    end
    $display("test_table done");
  endtask : test_table
  task automatic test_hold;
    do_reset(8'h7f, 1'b0);
    @(posedge sys_clk);
    board_cfg <= 8'h80;
    repeat (6) @(posedge sys_clk);
    #1;
    check_cfg(8'h7f);
    @(posedge sys_clk);
    serial_access <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("strap_mode", 1'b0, strap_mode)
    check_cfg(8'h7f);
    $display("test_hold done");
  endtask : test_hold
  task automatic test_serial_first;
    do_reset(8'h7f, 1'b1);
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK("strap_mode", 1'b0, strap_mode)
    `CHK("lanes_on", 1'b0, lanes_on)
    `CHK("pe_level", 2'h0, preemphasis_level)
    $display("test_serial_first done");
  endtask : test_serial_first
  initial begin
    test_table();
    test_hold();
    test_serial_first();
    finish_test();
  end
endmodule : tb_top
